// ===== modem_status_pkg.sv
// package with register map, field positions and reset values of the modem status block
package modem_status_pkg;
   localparam int ADDR_W = 4; // register bus address width
   localparam int DATA_W = 8; // register bus data width
   // register offsets
   localparam logic [3:0] OFS_MODEM_LINE_STATUS = 4'h0;
   localparam logic [3:0] OFS_INT_ENABLE = 4'h1;
   localparam logic [3:0] OFS_MODEM_CONTROL = 4'h2;
   localparam logic [3:0] OFS_IRQ_STATUS = 4'h3;
   localparam logic [3:0] OFS_IRQ_CLEAR = 4'h4;
   localparam logic [3:0] OFS_IRQ_ENABLE = 4'h5;
   // field positions in modem_line_status
   localparam int CTS_CHG_BIT = 0;
   localparam int DSR_CHG_BIT = 1;
   localparam int RING_TE_BIT = 2;
   localparam int CD_CHG_BIT = 3;
   localparam int LEVEL_LSB = 4;
   // field positions in interrupt enable and modem control
   localparam int IE_MODEM_BIT = 3;
   localparam int LOOPBACK_BIT = 4;
   // event bit positions in the sticky event register
   localparam int EV_CHANGE_BIT = 0;
   localparam int EV_READ_BIT = 1;
   // reset values
   localparam logic [7:0] INT_ENABLE_RST = 8'h00;
   localparam logic [4:0] MODEM_CONTROL_RST = 5'h00;
   localparam logic [3:0] CHANGE_FLAGS_RST = 4'h0;
   localparam logic [1:0] IRQ_EVENTS_RST = 2'h0;
   localparam logic [7:0] READ_ZERO = 8'h00;
endpackage

// ===== modem_status_change_detect.sv
// modem line status register with change flags, loopback and interrupt request
// Functional notes
// - 8-bit status: four levels, four change flags
// - change flag sets on line change, sticky
// - reading status register clears change flags
// - bit 0 flags a cts toggle
// - bit 1 flags a dsr toggle
// - bit 2 flags ring going on to off
// - bit 3 flags carrier detect toggle
// - any flag set raises modem interrupt
// - bit 4 is inverted cts pin
// - bit 5 is inverted dsr pin
// - bit 6 is inverted ring pin
// - bit 7 is inverted carrier detect pin
// - interrupt gated by enable register bit 3
// - loopback feeds control bits to inputs
// - host writes set the low flag bits
`timescale 1ns/1ns
module modem_status_change_detect (
   input wire logic CLK_I, // 10 MHz clock
   input wire logic SRST_I, // synchronous reset, active high
   input wire logic [modem_status_pkg::ADDR_W-1:0] ADDR_I, // register address
   input wire logic [modem_status_pkg::DATA_W-1:0] WDATA_I, // write data
   input wire logic WR_I, // write strobe
   input wire logic RD_I, // read strobe
   input wire logic CTS_N_I, // clear to send, active low pin
   input wire logic DSR_N_I, // data set ready, active low pin
   input wire logic RING_N_I, // ring indicator, active low pin
   input wire logic CD_N_I, // carrier detect, active low pin
   output logic [modem_status_pkg::DATA_W-1:0] RDATA_O, // read data, cycle after strobe
   output logic [3:0] MODEM_CTRL_O, // modem control bits 3..0 (drive pins through inverters)
   output logic INTERRUPT_REQUEST_OUT_O, // modem status interrupt, gated by enable
   output logic IRQ_O // summary interrupt from sticky event register
);
   import modem_status_pkg::*;

   logic [3:0] sync1_r; // first stage, read only by stage two
   logic [3:0] sync2_r; // second stage
   logic [3:0] sync3_r; // third stage
   logic [3:0] stable_r; // accepted active-low pin levels
   logic [3:0] level_r; // active-high line levels as seen by the logic
   logic seeded_r; // first level sample after reset done
   logic [3:0] fill_r; // marks stages that hold real pin samples since reset
   logic [3:0] change_flags_r; // sticky change flags
   logic [7:0] int_enable_r; // interrupt enable register
   logic [4:0] modem_control_r; // loopback plus four control bits
   logic [1:0] irq_events_r; // sticky events
   logic [1:0] irq_mask_r; // event enables
   logic [3:0] pin_level; // inverted, filtered pins
   logic [3:0] line_level; // after loopback selection
   logic [3:0] detect; // per-flag change detect this cycle
   logic [3:0] write_set; // flags set by host write
   logic rd_status; // clearing read of status register
   logic wr_status; // write to status register
   logic modem_irq; // raw modem status condition
   logic [1:0] ev_in; // events this cycle

   // address match helper, used by every decode except the read data case
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] ofs);
      hit = (a == ofs);
   endfunction

   assign rd_status = RD_I && hit(ADDR_I, OFS_MODEM_LINE_STATUS);
   assign wr_status = WR_I && hit(ADDR_I, OFS_MODEM_LINE_STATUS);

   // three-flop synchroniser; first flop feeds only the second
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         sync1_r <= 4'h0;
         sync2_r <= 4'h0;
         sync3_r <= 4'h0;
      end else begin
         sync1_r <= {CD_N_I, RING_N_I, DSR_N_I, CTS_N_I};
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   // a change counts only once stages two and three agree
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         stable_r <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (sync2_r[i] == sync3_r[i]) begin
               stable_r[i] <= sync3_r[i];
            end
         end
      end
   end

   // pins are active low, the register shows active-high levels
   assign pin_level = ~stable_r;

   // loopback replaces pins by the modem control bits
   assign line_level = modem_control_r[LOOPBACK_BIT] ? modem_control_r[3:0] : pin_level;

   // pipeline fill marker: a stage only counts once it holds a real pin sample
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         fill_r <= 4'h0;
      end else begin
         fill_r <= {fill_r[2:0], 1'b1};
      end
   end

   // reset levels are seeded silently: no change reported for the pin state at start
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         level_r <= 4'h0;
         seeded_r <= 1'b0;
      end else begin
         level_r <= line_level;
         // sticky; waits for real pin samples, else the reset zeros would read as edges
         seeded_r <= seeded_r || (fill_r[3] && (sync3_r == sync2_r) && (sync3_r == stable_r));
      end
   end

   // edge detect per line; ring sets on trailing edge only
   always_comb begin
      detect = 4'h0;
      if (seeded_r) begin
         detect[CTS_CHG_BIT] = line_level[0] ^ level_r[0];
         detect[DSR_CHG_BIT] = line_level[1] ^ level_r[1];
         detect[RING_TE_BIT] = level_r[2] && !line_level[2];
         detect[CD_CHG_BIT] = line_level[3] ^ level_r[3];
      end
   end

   // host writes of ones set the low bits for interrupt testing
   assign write_set = wr_status ? WDATA_I[3:0] : 4'h0;

   // sticky flags; a new set wins over a clearing read
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         change_flags_r <= CHANGE_FLAGS_RST;
      end else begin
         change_flags_r <= ((rd_status ? 4'h0 : change_flags_r)) | detect | write_set;
      end
   end

   // interrupt enable and modem control registers
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         int_enable_r <= INT_ENABLE_RST;
         modem_control_r <= MODEM_CONTROL_RST;
      end else if (WR_I) begin
         if (hit(ADDR_I, OFS_INT_ENABLE)) begin
            int_enable_r <= {4'h0, WDATA_I[3:0]};
         end
         if (hit(ADDR_I, OFS_MODEM_CONTROL)) begin
            modem_control_r <= WDATA_I[4:0];
         end
      end
   end

   assign modem_irq = |change_flags_r;
   assign INTERRUPT_REQUEST_OUT_O = modem_irq && int_enable_r[IE_MODEM_BIT];
   assign MODEM_CTRL_O = modem_control_r[3:0];

   // sticky events: any new flag, and each clearing read
   assign ev_in = {rd_status, |(detect | write_set)};

   // status set wins over clear in the same cycle
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         irq_events_r <= IRQ_EVENTS_RST;
         irq_mask_r <= IRQ_EVENTS_RST;
      end else begin
         irq_events_r <= (irq_events_r & ~((WR_I && hit(ADDR_I, OFS_IRQ_CLEAR)) ? WDATA_I[1:0] : 2'h0)) | ev_in;
         if (WR_I && hit(ADDR_I, OFS_IRQ_ENABLE)) begin
            irq_mask_r <= WDATA_I[1:0];
         end
      end
   end

   assign IRQ_O = |(irq_events_r & irq_mask_r);

   // read data registered, zero on unmapped or idle
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         RDATA_O <= READ_ZERO;
      end else if (RD_I) begin
         case (ADDR_I)
            OFS_MODEM_LINE_STATUS: RDATA_O <= {line_level, change_flags_r};
            OFS_INT_ENABLE: RDATA_O <= int_enable_r;
            OFS_MODEM_CONTROL: RDATA_O <= {3'h0, modem_control_r};
            OFS_IRQ_STATUS: RDATA_O <= {6'h00, irq_events_r};
            OFS_IRQ_ENABLE: RDATA_O <= {6'h00, irq_mask_r};
            default: RDATA_O <= READ_ZERO;
         endcase
      end else begin
         RDATA_O <= READ_ZERO;
      end
   end

   // helper delayed read flag for assertions
   logic rd_status_d_r;
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         rd_status_d_r <= 1'b0;
      end else begin
         rd_status_d_r <= rd_status;
      end
   end

   sequence s_clear_read;
      rd_status && (detect == 4'h0) && !wr_status;
   endsequence

   property p_clear_on_read;
      @(posedge CLK_I) disable iff (SRST_I) s_clear_read |=> (change_flags_r == 4'h0);
   endproperty
   a_clear_on_read: assert property (p_clear_on_read) else $error("flags not cleared by read");

   property p_sticky;
      @(posedge CLK_I) disable iff (SRST_I) (change_flags_r[0] && !rd_status) |=> change_flags_r[0];
   endproperty
   a_sticky: assert property (p_sticky) else $error("change flag lost");

   property p_cts_set;
      @(posedge CLK_I) disable iff (SRST_I) detect[CTS_CHG_BIT] |=> change_flags_r[CTS_CHG_BIT];
   endproperty
   a_cts_set: assert property (p_cts_set) else $error("cts flag not set");

   property p_dsr_set;
      @(posedge CLK_I) disable iff (SRST_I) (seeded_r && $changed(line_level[1])) |=> change_flags_r[1];
   endproperty
   a_dsr_set: assert property (p_dsr_set) else $error("dsr flag not set");

   property p_ring_rise_quiet;
      @(posedge CLK_I) disable iff (SRST_I)
         (!level_r[2] && line_level[2] && !change_flags_r[2] && !wr_status) |=> !change_flags_r[2];
   endproperty
   a_ring_rise_quiet: assert property (p_ring_rise_quiet) else $error("ring flag set on leading edge");

   property p_cd_set;
      @(posedge CLK_I) disable iff (SRST_I) (seeded_r && (line_level[3] != level_r[3])) |=> change_flags_r[3];
   endproperty
   a_cd_set: assert property (p_cd_set) else $error("carrier flag not set");

   property p_irq_gate;
      @(posedge CLK_I) disable iff (SRST_I)
         INTERRUPT_REQUEST_OUT_O == ((change_flags_r != 4'h0) && int_enable_r[3]);
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("modem interrupt wrong");

   property p_level_read;
      @(posedge CLK_I) disable iff (SRST_I) rd_status_d_r |-> (RDATA_O[7:4] == $past(line_level));
   endproperty
   a_level_read: assert property (p_level_read) else $error("status levels wrong");

   property p_write_set;
      @(posedge CLK_I) disable iff (SRST_I) (wr_status && WDATA_I[0]) |=> change_flags_r[0];
   endproperty
   a_write_set: assert property (p_write_set) else $error("write did not set flag");

   // a change in the same cycle as a clearing read must survive it
   sequence s_set_during_read;
      rd_status && (detect != 4'h0);
   endsequence

   property p_set_beats_read;
      @(posedge CLK_I) disable iff (SRST_I)
         s_set_during_read |=> ((change_flags_r & $past(detect)) == $past(detect));
   endproperty
   a_set_beats_read: assert property (p_set_beats_read) else $error("change lost to clearing read");

   // ring on to off must leave its flag set
   property p_ring_fall_set;
      @(posedge CLK_I) disable iff (SRST_I) (seeded_r && level_r[2] && !line_level[2]) |=> change_flags_r[RING_TE_BIT];
   endproperty
   a_ring_fall_set: assert property (p_ring_fall_set) else $error("ring trailing edge not flagged");

   // a fresh change with the modem enable set raises the request next cycle
   property p_irq_raise;
      @(posedge CLK_I) disable iff (SRST_I)
         ((detect != 4'h0) && int_enable_r[IE_MODEM_BIT] && !WR_I) |=> INTERRUPT_REQUEST_OUT_O;
   endproperty
   a_irq_raise: assert property (p_irq_raise) else $error("modem interrupt not raised");

   // no flag may appear while the synchroniser is still filling after reset
   property p_seed_quiet;
      @(posedge CLK_I) disable iff (SRST_I)
         (!seeded_r && !wr_status && (change_flags_r == 4'h0)) |=> (change_flags_r == 4'h0);
   endproperty
   a_seed_quiet: assert property (p_seed_quiet) else $error("flag raised before seeding");

   // in loopback the status levels come from the control bits, not the pins
   property p_loop_levels;
      @(posedge CLK_I) disable iff (SRST_I)
         (rd_status && modem_control_r[LOOPBACK_BIT]) |=> (RDATA_O[7:4] == $past(modem_control_r[3:0]));
   endproperty
   a_loop_levels: assert property (p_loop_levels) else $error("loopback levels wrong");

   // read data stands for one cycle only, zero otherwise
   property p_rdata_idle;
      @(posedge CLK_I) disable iff (SRST_I) !RD_I |=> (RDATA_O == READ_ZERO);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

   // a stage-two value is accepted only where stage three agrees with it
   property p_sync_agree;
      @(posedge CLK_I) disable iff (SRST_I)
         !$past(SRST_I) |-> (((stable_r ^ $past(stable_r)) & $past(sync2_r ^ sync3_r)) == 4'h0);
   endproperty
   a_sync_agree: assert property (p_sync_agree) else $error("unsettled pin accepted");
endmodule

// ===== modem_line_model.sv
// behavioural modem driving the four active-low handshake lines
`timescale 1ns/1ns
module modem_line_model (
   input wire logic clk_i, // system clock
   input wire logic [3:0] assert_i, // lines to assert, bit0 cts .. bit3 cd
   output logic cts_n_o, // clear to send, low when on
   output logic dsr_n_o, // data set ready, low when on
   output logic ring_n_o, // ring indicator, low when on
   output logic cd_n_o // carrier detect, low when on
);
   // lines move just after an edge; the block must resynchronise them
   // unknown only until the first edge, which falls inside reset
   always @(posedge clk_i) begin
      {cd_n_o, ring_n_o, dsr_n_o, cts_n_o} <= ~assert_i;
   end
endmodule

// ===== modem_status_change_detect_test.sv
// self-checking testbench for the modem status change detector
`timescale 1ns/1ns
module modem_status_change_detect_test;
   import modem_status_pkg::*;
   logic clk = 1'b0; // 10 MHz system clock
   logic srst = 1'b1; // synchronous reset
   logic [ADDR_W-1:0] addr = '0; // register address
   logic [DATA_W-1:0] wdata = '0; // write data
   logic wr = 1'b0; // write strobe
   logic rd = 1'b0; // read strobe
   logic [3:0] lv = 4'h0; // asserted lines, bit0 cts .. bit3 cd
   logic [3:0] nv; // next line state
   logic [3:0] fe; // expected change flags
   logic cts_n, dsr_n, ring_n, cd_n; // modem pins
   logic [7:0] rdat; // last read value
   logic [7:0] rdata; // design read data
   logic [3:0] mctl; // modem control outputs
   logic irq_modem, irq_sum; // interrupt outputs
   int bad_count = 0;
   int comparisons = 0;
   integer seed = 84;
   always #50 clk = ~clk;
   modem_line_model modem_line_model_inst (.clk_i(clk), .assert_i(lv), .cts_n_o(cts_n), .dsr_n_o(dsr_n),
      .ring_n_o(ring_n), .cd_n_o(cd_n));
   modem_status_change_detect modem_status_change_detect_inst (.CLK_I(clk), .SRST_I(srst), .ADDR_I(addr),
      .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .CTS_N_I(cts_n), .DSR_N_I(dsr_n), .RING_N_I(ring_n),
      .CD_N_I(cd_n), .RDATA_O(rdata), .MODEM_CTRL_O(mctl), .INTERRUPT_REQUEST_OUT_O(irq_modem), .IRQ_O(irq_sum));
   // ring only flags its trailing edge; the others flag either way
   function automatic logic [3:0] flags_of(input logic [3:0] o, input logic [3:0] n);
      return {o[3] ^ n[3], o[2] & ~n[2], o[1] ^ n[1], o[0] ^ n[0]};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 rdat = rdata;
   endtask
   // synchroniser needs a few cycles; eight leaves margin
   task automatic move(input logic [3:0] n);
      @(posedge clk);
      lv <= n;
      repeat (8) @(posedge clk);
      #1;
   endtask
   task automatic finish_test();
      $display("counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      repeat (8) @(posedge clk);
      rd_reg(OFS_MODEM_LINE_STATUS);
      chk(rdat, 8'h00);
      $display("test reset done");
      wr_reg(OFS_INT_ENABLE, 8'hF8);
      rd_reg(OFS_INT_ENABLE);
      chk(rdat, 8'h08);
      wr_reg(OFS_IRQ_ENABLE, 8'h01);
      move(4'h1);
      chk({7'h00, irq_modem}, 8'h01);
      chk({7'h00, irq_sum}, 8'h01);
      rd_reg(OFS_IRQ_STATUS);
      chk(rdat, 8'h03);
      wr_reg(OFS_IRQ_CLEAR, 8'h03);
      chk({7'h00, irq_sum}, 8'h00);
      wr_reg(OFS_IRQ_ENABLE, 8'h00);
      rd_reg(OFS_MODEM_LINE_STATUS);
      chk(rdat, 8'h11);
      rd_reg(OFS_MODEM_LINE_STATUS);
      chk({irq_modem, rdat[6:0]}, 8'h10);
      $display("test interrupt done");
      // host-written flags raise the modem interrupt only once the enable is set
      wr_reg(OFS_INT_ENABLE, 8'h00);
      wr_reg(OFS_MODEM_LINE_STATUS, 8'h0F);
      chk({7'h00, irq_modem}, 8'h00);
      wr_reg(OFS_INT_ENABLE, 8'h08);
      chk({7'h00, irq_modem}, 8'h01);
      rd_reg(OFS_MODEM_LINE_STATUS);
      chk(rdat, 8'h1F);
      $display("test flag write done");
      // corner: the line change lands in the cycle of a clearing read and must survive it
      @(posedge clk);
      fe = flags_of(lv, 4'h8);
      lv <= 4'h8;
      repeat (4) @(posedge clk);
      rd_reg(OFS_MODEM_LINE_STATUS);
      chk(rdat, 8'h80);
      rd_reg(OFS_MODEM_LINE_STATUS);
      chk(rdat, {4'h8, fe});
      $display("test read collision done");
      for (int i = 0; i < 24; i++) begin
         nv = 4'($random(seed));
         fe = flags_of(lv, nv);
         move(nv);
         chk({7'h00, irq_modem}, {7'h00, |fe});
         rd_reg(OFS_MODEM_LINE_STATUS);
         chk(rdat, {nv, fe});
      end
      $display("test random lines done");
      wr_reg(OFS_MODEM_CONTROL, 8'h1A);
      chk({4'h0, mctl}, 8'h0A);
      fe = flags_of(lv, 4'hA);
      rd_reg(OFS_MODEM_CONTROL);
      chk(rdat, 8'h1A);
      chk({7'h00, irq_modem}, {7'h00, |fe});
      repeat (6) @(posedge clk);
      rd_reg(OFS_MODEM_LINE_STATUS);
      chk(rdat, {4'hA, fe});
      wr_reg(OFS_MODEM_CONTROL, 8'h00);
      repeat (6) @(posedge clk);
      rd_reg(OFS_MODEM_LINE_STATUS);
      chk(rdat, {lv, flags_of(4'hA, lv)});
      rd_reg(OFS_MODEM_LINE_STATUS);
      chk(rdat, {lv, 4'h0});
      rd_reg(4'hF);
      chk(rdat, READ_ZERO);
      $display("test loopback done");
      finish_test();
   end
endmodule
